// ==== cbm_pkg.sv ====
// cbm_pkg: constants for the charger mode controller
// assumes a 200 MHz clock; register bus is a plain strobe port
`default_nettype none
package cbm_pkg;
  localparam int unsigned CLK_MHZ          = 200;
  // keepalive and safety timer periods, status pulse width
  localparam int unsigned KEEPALIVE_S      = 32;
  localparam int unsigned SAFETY_MIN       = 15;
  localparam int unsigned STAT_PULSE_US    = 128;
  localparam int unsigned STAT_PULSE_CYC   = STAT_PULSE_US * CLK_MHZ;
  // one tick per millisecond drives both long timers
  localparam int unsigned TICK_US          = 1000;
  localparam int unsigned TICK_CYC_DEF     = TICK_US * CLK_MHZ;
  localparam int unsigned KEEPALIVE_TICKS  = KEEPALIVE_S * 1000;
  localparam int unsigned SAFETY_TICKS     = SAFETY_MIN * 60 * 1000;
  // boost pulse timing in clock cycles
  localparam int unsigned TON_MIN_CYC      = 20;
  localparam int unsigned TON_SKIP_CYC     = 60;
  localparam int unsigned TOFF_MIN_CYC     = 20;
  // register map
  localparam logic [3:0] ADDR_STATUS       = 4'h0;
  localparam logic [3:0] ADDR_CONTROL      = 4'h1;
  localparam logic [3:0] ADDR_SAFETY       = 4'h6;
  // control register fields and register reset values
  localparam int unsigned BIT_BOOST_REQ    = 0;
  localparam int unsigned BIT_HIZ_REQ      = 1;
  localparam int unsigned BIT_INHIBIT      = 2;
  localparam int unsigned BIT_OTG_POL      = 3;
  localparam int unsigned BIT_KICK         = 6;
  localparam int unsigned BIT_RESET        = 7;
  localparam logic [7:0] CONTROL_RST       = 8'h00;
  localparam logic [7:0] SAFETY_RST        = 8'h01;
  // status field positions and fault codes
  localparam int unsigned STAT_MODE_LSB    = 4;
  localparam logic [2:0] FAULT_NONE        = 3'h0;
  localparam logic [2:0] FAULT_TIMER       = 3'h6;
  localparam logic [2:0] FAULT_BST_UVLO    = 3'h3;
  // synchroniser reset levels: every input at its idle, inactive level
  localparam logic [8:0] SYNC_IDLE         = 9'h02e;
  typedef enum logic [1:0] {
    CBM_CHARGE    = 2'b00,
    CBM_CONFIGURE = 2'b01,
    CBM_BOOST     = 2'b10,
    CBM_HIZ       = 2'b11
  } cbm_mode_t;
  typedef enum logic [1:0] {
    CBM_B_OFF = 2'b00,
    CBM_B_LIN = 2'b01,
    CBM_B_SS  = 2'b10,
    CBM_B_RUN = 2'b11
  } cbm_bst_t;
endpackage : cbm_pkg
`default_nettype wire

// ==== cbm_ctrl.sv ====
// cbm_ctrl: mode control, keepalive and safety timers, boost sequencer
// assumes analog comparators arrive as asynchronous levels
//
// Chosen here: the plain strobed port and the register addresses.
`default_nettype none
// Summary of operation
// - hiz request or inhibit stops charging, enters hiz, clears keepalive timer
// - in hiz with low battery keepalive runs; overflow resets registers but safety
// - safety timer overflow sets the inhibit bit and enters hiz
// - after that, a host write, bus power-on or keepalive expiry restarts charging
// - reset bit returns every register but safety to default, clearing hiz and inhibit
// - reset with hiz or inhibit set keeps timer stopped and stays hiz
// - charge only when disable pin, inhibit and hiz request are all zero
// - disable pin high freezes keepalive timer without clearing it
// - disable pin rising during timed charging clears the safety timer
// - mode: hiz request with otg pin inactive, else fault gives configure, else boost enable picks
// - boost request bit clears whenever boost ends
// - boost allowed only in keepalive timed mode
// - otg pin active when equal to polarity bit
// - active otg pin boosts despite hiz; hiz overrides software boost request
// - boost on active otg, or boost request with hiz clear
// - keepalive expiry in boost resets registers, pulses status, fault 110
// - latched fault clears on bus power-on or status register read
// - output above reference after off-time enters pulse skip, inhibits pulses
// - pulse skip lengthens minimum on-time
// - boost sequence: linear start, soft start, run
// - fault code sits in status register bits 2 to 0
// - a fault with none latched drives status pin low for 128 us then releases
// - boost timer fault is code 110 and resets all registers but safety
module cbm_ctrl #(
  parameter int unsigned TICK_CYC = cbm_pkg::TICK_CYC_DEF,
  parameter int unsigned KA_TICKS = cbm_pkg::KEEPALIVE_TICKS,
  parameter int unsigned SF_TICKS = cbm_pkg::SAFETY_TICKS,
  parameter int unsigned PULSE_CYC = cbm_pkg::STAT_PULSE_CYC
) (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst_n,
  // register port
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output var  logic [7:0] reg_rdata_q,
  // pins and comparators
  input  wire logic       disable_pin,
  input  wire logic       otg_pin,
  input  wire logic       bus_power_on_event,
  input  wire logic       bat_low,
  input  wire logic       bat_above_out,
  input  wire logic       out_below_target,
  input  wire logic       bat_above_uvlo,
  input  wire logic       out_above_ref,
  input  wire logic       ext_fault,
  input  wire logic [2:0] ext_fault_code,
  // outputs
  output var  logic       charge_en_q,
  output var  logic       hiz_q,
  output var  logic [1:0] mode_q,
  output var  logic [1:0] boost_run_state_q,
  output var  logic       pulse_skip_mode_q,
  output var  logic       boost_switch_q,
  output var  logic       stat_oe_q,
  output var  logic       stat_out_q
);
  initial begin
    if (TICK_CYC < 2 || KA_TICKS < 2 || SF_TICKS < 2 || PULSE_CYC < 2)
      $error("cbm_ctrl: counts too small");
  end

  // three-stage input synchronisers; first stage feeds only the second
  logic [8:0] s1_q, s2_q, s3_q, in_q;
  wire  [8:0] raw_in = {ext_fault, bus_power_on_event, disable_pin, otg_pin, bat_low,
                        bat_above_out, out_below_target, bat_above_uvlo, out_above_ref};
  genvar gi;
  generate
    for (gi = 0; gi < 9; gi++)
    begin : g_sync
      always_ff @(posedge clock or negedge rst_n)
      begin
        if (!rst_n)
        begin
          // idle levels, so leaving reset shows no false edge or fault
          s1_q[gi] <= cbm_pkg::SYNC_IDLE[gi];
          s2_q[gi] <= cbm_pkg::SYNC_IDLE[gi];
          s3_q[gi] <= cbm_pkg::SYNC_IDLE[gi];
          in_q[gi] <= cbm_pkg::SYNC_IDLE[gi];
        end else begin
          s1_q[gi] <= raw_in[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
          if (s2_q[gi] == s3_q[gi])
            in_q[gi] <= s3_q[gi];
        end
      end
    end
  endgenerate
  wire dis_s = in_q[6], otg_s = in_q[5], blow_s = in_q[4];
  wire bao_s = in_q[3], obt_s = in_q[2], uvlo_s = in_q[1], oref_s = in_q[0];
  wire flt_s = in_q[8], por_s = in_q[7];
  logic por_prev_q, dis_prev_q;
  wire por_rise = por_s & ~por_prev_q;
  wire dis_rise = dis_s & ~dis_prev_q;

  // registers
  logic [7:0] ctrl_q, safety_q;
  logic [2:0] fault_q;
  logic       fault_lat_q;
  logic       sf_inhibit_q;
  logic       ka_hold_q;
  logic [$clog2(TICK_CYC)-1:0] tick_cnt_q;
  logic [$clog2(KA_TICKS)-1:0] ka_cnt_q;
  logic [$clog2(SF_TICKS)-1:0] sf_cnt_q;
  logic [$clog2(PULSE_CYC)-1:0] pulse_cnt_q;
  cbm_pkg::cbm_bst_t bst_q;
  logic [7:0] pwm_cnt_q;
  logic       pwm_on_q;

  wire boost_req = ctrl_q[cbm_pkg::BIT_BOOST_REQ];
  wire hiz_req   = ctrl_q[cbm_pkg::BIT_HIZ_REQ];
  wire inhibit   = ctrl_q[cbm_pkg::BIT_INHIBIT];
  wire wr_ctrl   = reg_wr && reg_addr == cbm_pkg::ADDR_CONTROL;
  wire wr_safety = reg_wr && reg_addr == cbm_pkg::ADDR_SAFETY;
  wire rd_status = reg_rd && reg_addr == cbm_pkg::ADDR_STATUS;
  wire soft_rst  = wr_ctrl && reg_wdata[cbm_pkg::BIT_RESET];
  wire kick      = wr_ctrl && reg_wdata[cbm_pkg::BIT_KICK];
  wire tick      = tick_cnt_q == ($clog2(TICK_CYC))'(TICK_CYC - 1);

  wire otg_active = otg_s == ctrl_q[cbm_pkg::BIT_OTG_POL];
  wire timed_mode = ~ka_hold_q;
  wire boost_en   = timed_mode & (otg_active | (boost_req & ~hiz_req)) & ~fault_lat_q;
  wire hiz_now    = (hiz_req | inhibit) & ~otg_active;
  wire charge_ok  = ~dis_s & ~inhibit & ~hiz_req & ~boost_en & ~ka_hold_q;
  wire [1:0] mode_d = hiz_req && !otg_active ? cbm_pkg::CBM_HIZ :
                      fault_lat_q ? cbm_pkg::CBM_CONFIGURE :
                      boost_en ? cbm_pkg::CBM_BOOST : cbm_pkg::CBM_CHARGE;
  wire ka_ovf = tick && ka_cnt_q == ($clog2(KA_TICKS))'(KA_TICKS - 1);
  wire sf_ovf = tick && sf_cnt_q == ($clog2(SF_TICKS))'(SF_TICKS - 1);
  wire in_boost = bst_q != cbm_pkg::CBM_B_OFF;
  wire boost_tmo = ka_ovf & in_boost;
  wire hiz_tmo   = ka_ovf & hiz_now & blow_s & ~in_boost;
  wire boost_flt = in_boost & bst_q == cbm_pkg::CBM_B_SS & ~uvlo_s;
  wire new_fault = boost_tmo | flt_s | boost_flt;
  wire [2:0] fault_code = boost_tmo ? cbm_pkg::FAULT_TIMER :
                          boost_flt ? cbm_pkg::FAULT_BST_UVLO : ext_fault_code;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      por_prev_q <= 1'b0;
      dis_prev_q <= 1'b0;
      tick_cnt_q <= '0;
    end else begin
      por_prev_q <= por_s;
      dis_prev_q <= dis_s;
      tick_cnt_q <= tick ? '0 : tick_cnt_q + 1'b1;
    end
  end

  // control register with hardware sets and clears
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_q       <= cbm_pkg::CONTROL_RST;
      safety_q     <= cbm_pkg::SAFETY_RST;
      sf_inhibit_q <= 1'b0;
      ka_hold_q    <= 1'b0;
    end else begin
      if (wr_safety)
        safety_q <= reg_wdata;
      // register reset; with hiz or inhibit set, hiz held with timer stopped
      if (soft_rst)
      begin
        ctrl_q    <= cbm_pkg::CONTROL_RST;
        ka_hold_q <= hiz_req | inhibit;
      end else if (boost_tmo || hiz_tmo)
      begin
        ctrl_q    <= cbm_pkg::CONTROL_RST;
        ka_hold_q <= 1'b0;
      end else begin
        if (wr_ctrl)
        begin
          ctrl_q <= reg_wdata & 8'h3f;
          ka_hold_q <= 1'b0;
        end
        // boost request drops when boost ends, by fault too
        if (in_boost && (!boost_en || new_fault))
          ctrl_q[cbm_pkg::BIT_BOOST_REQ] <= 1'b0;
      end
      // safety overflow sets inhibit; set wins over writes and resets
      if (sf_ovf)
        ctrl_q[cbm_pkg::BIT_INHIBIT] <= 1'b1;
      // only host write or power-on releases the timer inhibit
      if (sf_ovf)
        sf_inhibit_q <= 1'b1;
      else if (wr_ctrl || por_rise)
        sf_inhibit_q <= 1'b0;
      if (por_rise && sf_inhibit_q && !sf_ovf)
        ctrl_q[cbm_pkg::BIT_INHIBIT] <= 1'b0;
    end
  end

  // keepalive and safety counters on the shared tick
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ka_cnt_q <= '0;
      sf_cnt_q <= '0;
    end else begin
      // clear on hiz entry, kick or hold
      if (ka_hold_q || kick || ka_ovf || (wr_ctrl && (reg_wdata[cbm_pkg::BIT_HIZ_REQ]
          || reg_wdata[cbm_pkg::BIT_INHIBIT])))
        ka_cnt_q <= '0;
      else if (tick && !dis_s && (in_boost || (hiz_now && blow_s) || !hiz_now))
        ka_cnt_q <= ka_cnt_q + 1'b1;
      if (dis_rise || sf_ovf || !charge_ok || safety_q == 8'h00)
        sf_cnt_q <= '0;
      else if (tick)
        sf_cnt_q <= sf_cnt_q + 1'b1;
    end
  end

  // fault latch, new fault wins over clear
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fault_q     <= cbm_pkg::FAULT_NONE;
      fault_lat_q <= 1'b0;
    end else if (new_fault)
    begin
      fault_q     <= fault_code;
      fault_lat_q <= 1'b1;
    end else if (rd_status || por_rise)
    begin
      fault_q     <= cbm_pkg::FAULT_NONE;
      fault_lat_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pulse_cnt_q <= '0;
      stat_oe_q   <= 1'b0;
    end else if (new_fault && !fault_lat_q)
    begin
      pulse_cnt_q <= ($clog2(PULSE_CYC))'(PULSE_CYC - 1);
      stat_oe_q   <= 1'b1;
    end else if (pulse_cnt_q != '0)
      pulse_cnt_q <= pulse_cnt_q - 1'b1;
    else
      stat_oe_q <= 1'b0;
  end

  cbm_pkg::cbm_bst_t bst_d;
  always_comb
  begin
    bst_d = bst_q;
    case (bst_q)
      cbm_pkg::CBM_B_OFF: if (boost_en) bst_d = cbm_pkg::CBM_B_LIN;
      cbm_pkg::CBM_B_LIN: if (!bao_s) bst_d = cbm_pkg::CBM_B_SS;
      cbm_pkg::CBM_B_SS:  if (!obt_s && uvlo_s) bst_d = cbm_pkg::CBM_B_RUN;
      cbm_pkg::CBM_B_RUN: bst_d = cbm_pkg::CBM_B_RUN;
      default:            bst_d = cbm_pkg::CBM_B_OFF;
    endcase
    if (!boost_en || new_fault)
      bst_d = cbm_pkg::CBM_B_OFF;
  end

  wire toff_done = !pwm_on_q && pwm_cnt_q >= 8'(cbm_pkg::TOFF_MIN_CYC);
  wire [7:0] ton_len = pulse_skip_mode_q ? 8'(cbm_pkg::TON_SKIP_CYC)
                                         : 8'(cbm_pkg::TON_MIN_CYC);
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bst_q             <= cbm_pkg::CBM_B_OFF;
      pwm_cnt_q         <= '0;
      pwm_on_q          <= 1'b0;
      pulse_skip_mode_q <= 1'b0;
      boost_switch_q    <= 1'b0;
    end else begin
      bst_q <= bst_d;
      if (bst_q != cbm_pkg::CBM_B_RUN)
      begin
        pwm_on_q       <= 1'b0;
        pwm_cnt_q      <= '0;
        boost_switch_q <= 1'b0;
        pulse_skip_mode_q <= 1'b0;
      end else if (pwm_on_q)
      begin
        if (pwm_cnt_q >= ton_len - 8'h01)
        begin
          pwm_on_q       <= 1'b0;
          pwm_cnt_q      <= '0;
          boost_switch_q <= 1'b0;
        end else
          pwm_cnt_q <= pwm_cnt_q + 8'h01;
      end else if (toff_done)
      begin
        // decided when off-time first ends, so the pulse after a skip keeps the long on-time
        if (pwm_cnt_q == 8'(cbm_pkg::TOFF_MIN_CYC))
          pulse_skip_mode_q <= oref_s;
        if (!oref_s)
        begin
          pwm_on_q       <= 1'b1;
          pwm_cnt_q      <= '0;
          boost_switch_q <= 1'b1;
        end else if (pwm_cnt_q != 8'hff)
          pwm_cnt_q <= pwm_cnt_q + 8'h01;
      end else
        pwm_cnt_q <= pwm_cnt_q + 8'h01;
    end
  end

  // outputs and read port
  wire [7:0] status_rd = {2'b00, mode_q, 1'b0, fault_q};
  wire [7:0] rd_mux = reg_addr == cbm_pkg::ADDR_STATUS  ? status_rd :
                      reg_addr == cbm_pkg::ADDR_CONTROL ? ctrl_q :
                      reg_addr == cbm_pkg::ADDR_SAFETY  ? safety_q : 8'h00;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata_q       <= 8'h00;
      charge_en_q       <= 1'b0;
      hiz_q             <= 1'b0;
      mode_q            <= cbm_pkg::CBM_CHARGE;
      boost_run_state_q <= cbm_pkg::CBM_B_OFF;
      stat_out_q        <= 1'b0;
    end else begin
      reg_rdata_q       <= reg_rd ? rd_mux : 8'h00;
      charge_en_q       <= charge_ok & ~fault_lat_q;
      hiz_q             <= hiz_now | ka_hold_q;
      mode_q            <= mode_d;
      boost_run_state_q <= bst_d;
      stat_out_q        <= 1'b0;
    end
  end

  // charge enable needs all three low
  a_charge_gate: assert property (@(posedge clock) disable iff (!rst_n)
    charge_en_q |-> $past(!dis_s && !inhibit && !hiz_req)) else $error("charge with inhibit");
  a_fault_pulse: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(stat_oe_q) |-> stat_oe_q [*8]) else $error("status pulse too short");
  a_timer_code: assert property (@(posedge clock) disable iff (!rst_n)
    boost_tmo |=> fault_q == cbm_pkg::FAULT_TIMER && ctrl_q == cbm_pkg::CONTROL_RST)
    else $error("timer fault not taken");
  a_safety_inh: assert property (@(posedge clock) disable iff (!rst_n)
    sf_ovf && !soft_rst |=> inhibit) else $error("safety overflow lost");
  a_fault_clear: assert property (@(posedge clock) disable iff (!rst_n)
    rd_status && !new_fault |=> !fault_lat_q) else $error("fault not cleared");
  a_freeze_ka: assert property (@(posedge clock) disable iff (!rst_n)
    dis_s && !kick && !ka_hold_q && !wr_ctrl && !ka_ovf |=> $stable(ka_cnt_q))
    else $error("keepalive moved");
  a_hiz_boost: assert property (@(posedge clock) disable iff (!rst_n)
    hiz_req && !otg_active |-> !boost_en) else $error("hiz ignored");
  a_reset_hold: assert property (@(posedge clock) disable iff (!rst_n)
    soft_rst && (hiz_req || inhibit) |=> ka_hold_q ##1 hiz_q) else $error("reset left hiz");
endmodule // cbm_ctrl
`default_nettype wire

// ==== cbm_env_model.sv ====
// cbm_env_model: behavioural stand-in for the boost power stage comparators
// assumes the controller's registered boost state and switch outputs
`default_nettype none
module cbm_env_model (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst_n,
  // from the controller
  input  wire logic [1:0] boost_run_state_q,
  input  wire logic       boost_switch_q,
  // comparator levels back to the controller
  output wire logic       bat_above_out,
  output wire logic       out_below_target,
  output wire logic       bat_above_uvlo,
  output wire logic       out_above_ref
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] prev_q;
  logic [7:0] stay_q;
  logic [7:0] high_q;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prev_q <= 2'h0;
      stay_q <= 8'h00;
      high_q <= 8'h00;
    end
    else
    begin
      prev_q <= boost_run_state_q;
      stay_q <= (boost_run_state_q != prev_q) ? 8'h00 : stay_q + {7'h00, stay_q != 8'hff};
      // each switch pulse pushes the output over the reference for a while
      high_q <= boost_switch_q ? 8'h1e : high_q - {7'h00, high_q != 8'h00};
    end
  end
  // output climbs past battery, then reaches target
  assign bat_above_out    = (boost_run_state_q == cbm_pkg::CBM_B_OFF) ||
                            (boost_run_state_q == cbm_pkg::CBM_B_LIN && stay_q < 8'h06);
  assign out_below_target = (boost_run_state_q inside {cbm_pkg::CBM_B_OFF, cbm_pkg::CBM_B_LIN}) ||
                            (boost_run_state_q == cbm_pkg::CBM_B_SS && stay_q < 8'h06);
  // battery kept healthy: no undervoltage fault is commanded
  assign bat_above_uvlo   = 1'b1;
  assign out_above_ref    = (boost_run_state_q == cbm_pkg::CBM_B_RUN) && (high_q != 8'h00);
endmodule // cbm_env_model
`default_nettype wire

// ==== charger_boost_mode_control_bench.sv ====
// charger_boost_mode_control_bench: register-level tests of cbm_ctrl
// assumes cbm_pkg and cbm_env_model are compiled first
`default_nettype none
module charger_boost_mode_control_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned TICK = 8;
  localparam int unsigned KA = 16;
  localparam int unsigned SF = 32;
  localparam int unsigned PULSE = 10;
  logic       clock = 1'b0;
  logic       rst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic       disable_pin = 1'b0;
  // inactive for the reset polarity
  logic       otg_pin = 1'b1;
  logic       bus_power_on_event = 1'b0;
  logic       bat_low = 1'b0;
  logic       ext_fault = 1'b0;
  logic [2:0] ext_fault_code = 3'h0;
  wire  [7:0] reg_rdata_q;
  wire        bat_above_out, out_below_target, bat_above_uvlo, out_above_ref;
  wire        charge_en_q, hiz_q, pulse_skip_mode_q, boost_switch_q, stat_oe_q;
  wire  [1:0] mode_q, boost_run_state_q;
  int         fails = 0;
  int         compares = 0;
  int         n;
  logic [7:0] got;
  always #2.5 clock = ~clock;
  // short tick and counts keep the whole run to about a thousand cycles
  cbm_ctrl #(.TICK_CYC(TICK), .KA_TICKS(KA), .SF_TICKS(SF), .PULSE_CYC(PULSE)) DUT (
    .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .disable_pin(disable_pin), .otg_pin(otg_pin), .bus_power_on_event(bus_power_on_event),
    .bat_low(bat_low), .bat_above_out(bat_above_out), .out_below_target(out_below_target),
    .bat_above_uvlo(bat_above_uvlo), .out_above_ref(out_above_ref), .ext_fault(ext_fault),
    .ext_fault_code(ext_fault_code), .charge_en_q(charge_en_q), .hiz_q(hiz_q),
    .mode_q(mode_q), .boost_run_state_q(boost_run_state_q),
    .pulse_skip_mode_q(pulse_skip_mode_q), .boost_switch_q(boost_switch_q),
    .stat_oe_q(stat_oe_q), .stat_out_q());
  cbm_env_model env (
    .clock(clock), .rst_n(rst_n), .boost_run_state_q(boost_run_state_q),
    .boost_switch_q(boost_switch_q), .bat_above_out(bat_above_out),
    .out_below_target(out_below_target), .bat_above_uvlo(bat_above_uvlo),
    .out_above_ref(out_above_ref));
  task automatic report_and_stop();
    $display("errors %0d compares %0d", fails, compares);
    if (fails == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e)
    begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  // data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata_q;
  endtask
  function automatic logic [7:0] probe(input int sel);
    case (sel)
      0: probe = {6'h00, mode_q};
      1: probe = {7'h00, charge_en_q};
      2: probe = {6'h00, boost_run_state_q};
      3: probe = {7'h00, stat_oe_q};
      5: probe = {7'h00, pulse_skip_mode_q};
      default: probe = {7'h00, hiz_q};
    endcase
  endfunction
  // bounded wait; a miss is reported through chk with the last value seen
  task automatic wait_for(input int sel, input logic [7:0] e, input int bound);
    int i;
    for (i = 0; i < bound && probe(sel) !== e; i++)
    begin
      @(posedge clock);
      #1;
    end
    chk(probe(sel), e);
    if (probe(sel) !== e)
      report_and_stop();
  endtask
  initial
  begin
    #200000;
    fails++;
    report_and_stop();
  end
  initial
  begin
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    rd(cbm_pkg::ADDR_CONTROL, got); chk(got, cbm_pkg::CONTROL_RST);
    rd(cbm_pkg::ADDR_SAFETY, got); chk(got, cbm_pkg::SAFETY_RST);
    rd(4'h9, got); chk(got, 8'h00);
    wait_for(0, {6'h00, cbm_pkg::CBM_CHARGE}, 20);
    wait_for(1, 8'h01, 20);
    disable_pin <= 1'b1;
    wait_for(1, 8'h00, 20);
    disable_pin <= 1'b0;
    wait_for(1, 8'h01, 20);
    wr(cbm_pkg::ADDR_CONTROL, 8'h02);
    wait_for(0, {6'h00, cbm_pkg::CBM_HIZ}, 20);
    chk({7'h00, charge_en_q}, 8'h00);
    wr(cbm_pkg::ADDR_CONTROL, 8'h04);
    wait_for(4, 8'h01, 20);
    chk({7'h00, charge_en_q}, 8'h00);
    wr(cbm_pkg::ADDR_CONTROL, 8'h80);
    rd(cbm_pkg::ADDR_CONTROL, got); chk(got, 8'h00);
    repeat (4) @(posedge clock);
    #1 chk({7'h00, hiz_q}, 8'h01);
    chk({7'h00, charge_en_q}, 8'h00);
    // active pin must not boost while the keepalive is held
    otg_pin <= 1'b0;
    repeat (8) @(posedge clock);
    #1 chk(probe(2), {6'h00, cbm_pkg::CBM_B_OFF});
    otg_pin <= 1'b1;
    // software boost, then high-impedance overrides it
    wr(cbm_pkg::ADDR_CONTROL, 8'h01);
    wait_for(0, {6'h00, cbm_pkg::CBM_BOOST}, 20);
    wait_for(2, {6'h00, cbm_pkg::CBM_B_RUN}, 60);
    wr(cbm_pkg::ADDR_CONTROL, 8'h03);
    wait_for(0, {6'h00, cbm_pkg::CBM_HIZ}, 20);
    rd(cbm_pkg::ADDR_CONTROL, got); chk(got, 8'h02);
    // pin boost with both polarities despite high-impedance
    wr(cbm_pkg::ADDR_CONTROL, 8'h0a);
    otg_pin <= 1'b1;
    wait_for(0, {6'h00, cbm_pkg::CBM_BOOST}, 20);
    otg_pin <= 1'b0;
    wait_for(0, {6'h00, cbm_pkg::CBM_HIZ}, 20);
    wr(cbm_pkg::ADDR_CONTROL, 8'h02);
    wait_for(0, {6'h00, cbm_pkg::CBM_BOOST}, 20);
    otg_pin <= 1'b1;
    wait_for(0, {6'h00, cbm_pkg::CBM_HIZ}, 20);
    // kicks keep boost alive well past one timeout
    wr(cbm_pkg::ADDR_CONTROL, 8'h01);
    for (n = 0; n < 40; n++)
    begin
      wr(cbm_pkg::ADDR_CONTROL, 8'h41);
      repeat (8) @(posedge clock);
    end
    #1 chk({6'h00, mode_q}, {6'h00, cbm_pkg::CBM_BOOST});
    wait_for(5, 8'h01, 100);
    wait_for(3, 8'h01, 400);
    for (n = 0; n < 100 && stat_oe_q === 1'b1; n++)
    begin
      @(posedge clock);
      #1;
    end
    chk(8'(n), 8'(PULSE));
    if (n == 100)
      report_and_stop();
    rd(cbm_pkg::ADDR_STATUS, got); chk({5'h00, got[2:0]}, {5'h00, cbm_pkg::FAULT_TIMER});
    rd(cbm_pkg::ADDR_CONTROL, got); chk(got, 8'h00);
    rd(cbm_pkg::ADDR_STATUS, got); chk({5'h00, got[2:0]}, {5'h00, cbm_pkg::FAULT_NONE});
    // timed charging runs out and inhibits itself
    wait_for(4, 8'h01, 1000);
    rd(cbm_pkg::ADDR_CONTROL, got); chk(got, 8'h04);
    // low battery in hiz lets keepalive expire; all but safety reset
    wr(cbm_pkg::ADDR_SAFETY, 8'h05);
    bat_low <= 1'b1;
    wait_for(4, 8'h00, 300);
    rd(cbm_pkg::ADDR_CONTROL, got); chk(got, 8'h00);
    rd(cbm_pkg::ADDR_SAFETY, got); chk(got, 8'h05);
    report_and_stop();
  end
endmodule // charger_boost_mode_control_bench
`default_nettype wire
